/* File: cca_regs.svh */
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH

// Register indices; the byte address is four times the index.
`define CCA_IDX_CONFIG      16'ha078
`define CCA_IDX_DATA0       16'ha07c
`define CCA_IDX_DATA1       16'ha07d
`define CCA_IDX_DATA2       16'ha07e
`define CCA_IDX_DATA3       16'ha07f
`define CCA_ADDR_CONFIG     32'h0002_81e0
`define CCA_ADDR_DATA0      32'h0002_81f0
`define CCA_ADDR_DATA1      32'h0002_81f4
`define CCA_ADDR_DATA2      32'h0002_81f8
`define CCA_ADDR_DATA3      32'h0002_81fc

// Configuration field positions.
`define CCA_CFG_WIDTH_HI    7
`define CCA_CFG_WIDTH_LO    6
`define CCA_CFG_REVERSE     5
`define CCA_CFG_DISCARD     4
`define CCA_CFG_SEED        3
`define CCA_CFG_MODE_HI     2
`define CCA_CFG_MODE_LO     0
`define CCA_CFG_BUSY        0

// Reset values.
`define CCA_CONFIG_RST      8'h00
`define CCA_DATA_RST        32'h0000_0000

// Default seeds and polynomials.
`define CCA_SEED_CKSUM      32'h0000_0000
`define CCA_SEED_CRC16      32'h0000_ffff
`define CCA_SEED_CRC32      32'hffff_ffff
`define CCA_POLY_CRC16A     32'h0000_8005
`define CCA_POLY_CRC16B     32'h0000_1021
`define CCA_POLY_CRC32      32'h04c1_1db7
`define CCA_MASK_8          32'h0000_00ff
`define CCA_MASK_16         32'h0000_ffff
`define CCA_MASK_32         32'hffff_ffff

`endif

/* File: cca_pkg.sv */
package cca_pkg;

    // Engine mode codes as written to the mode field.
    typedef enum logic [2:0] {
        CCA_MODE_OFF   = 3'h0,
        CCA_MODE_CS8   = 3'h1,
        CCA_MODE_CS32  = 3'h2,
        CCA_MODE_CRC16A = 3'h3,
        CCA_MODE_CRC16B = 3'h4,
        CCA_MODE_CRC32 = 3'h5,
        CCA_MODE_RSVD  = 3'h6,
        CCA_MODE_CLEAR = 3'h7
    } cca_mode_t;

    // Calculation sequencer states.
    typedef enum logic [1:0] {
        CCA_ST_IDLE = 2'b01,
        CCA_ST_CALC = 2'b10
    } cca_state_t;

    // Stored configuration fields.
    typedef struct packed {
        logic [1:0] input_width_sel;
        logic       reverse;
        logic       carry_discard;
        logic       seed;
        cca_mode_t  engine_mode_sel;
    } cca_cfg_t;

endpackage

/* File: cca_accel.sv */
`include "cca_regs.svh"

// Overview of operation
// - Calculation takes one cycle per byte: 8-bit one, 16-bit two, 32-bit four.
// - Width field 00/01/10/11 selects 8, 16, 24 or 32-bit input words.
// - Bit order flip 0 feeds data LSB first, 1 feeds MSB first.
// - With flip set, data is mirrored across the selected width.
// - Flip never changes result readback or seed bit order.
// - Checksum carry discard 0 adds previous carry, 1 drops it.
// - With seed entry set, a completed entry loads the running state.
// - Mode 000 disables the engine.
// - Mode 001 is 8-bit checksum, 010 is 32-bit checksum, 110 reserved.
// - Mode 011 computes CRC-16 with polynomial 0x8005.
// - Mode 100 computes CRC-16 with polynomial 0x1021.
// - Mode 101 computes CRC-32 with polynomial 0x104C11DB7.
// - Writing mode 111 clears state and restores default seed.
// - The clear command keeps the previously selected mode.
// - Busy status reads 1 while a result is incomplete.
// - Writing the lowest data byte starts calculation with held upper bytes, unless seeding or the engine is off.
// - Data byte reads return the running result, bit 31 most significant.
module cca_accel (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             busy_out
);

    cca_pkg::cca_cfg_t   cfg_reg;
    cca_pkg::cca_state_t state_reg;
    logic [23:0] upper_reg;
    logic [31:0] result_reg;
    logic        carry_reg;
    logic [31:0] word_reg;
    logic [1:0]  idx_reg;
    logic [1:0]  last_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;

    logic        setup_phase;
    logic        addr_hit;
    logic        wr_fire;
    logic        wr_cfg;
    logic        wr_d0;
    logic        wr_d1;
    logic        wr_d2;
    logic        wr_d3;
    logic        start;
    logic        clear_cmd;
    logic        engine_on;
    logic [31:0] entry;
    logic [31:0] mask_w;
    logic [31:0] rev8;
    logic [31:0] rev16;
    logic [31:0] rev24;
    logic [31:0] rev32;
    logic [31:0] eng_word;
    logic [7:0]  cur_byte;
    logic        carry_in;
    logic [8:0]  sum9;
    logic [32:0] sum33;
    logic [31:0] crc_next;
    logic [31:0] seed_dflt;
    logic [31:0] res_mask;
    logic [7:0]  rd_byte;

    // Process one byte LSB first through a shift-left CRC register.
    function automatic logic [31:0] crc_byte(
        input logic [31:0] s_in,
        input logic [7:0]  b,
        input logic        wide,
        input logic [31:0] poly
    );
        logic [31:0] s;
        logic        fb;
        s = s_in;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fb = (wide ? s[31] : s[15]) ^ b[i];
            s = {s[30:0], 1'b0};
            if (fb) begin
                s = s ^ poly;
            end
        end
        if (!wide) begin
            s[31:16] = 16'h0000;
        end
        return s;
    endfunction

    // APB decode; every register takes one aligned word.
    assign setup_phase = psel_in && !penable_in;
    assign addr_hit = (paddr_in == `CCA_ADDR_CONFIG) || (paddr_in == `CCA_ADDR_DATA0)
                   || (paddr_in == `CCA_ADDR_DATA1) || (paddr_in == `CCA_ADDR_DATA2)
                   || (paddr_in == `CCA_ADDR_DATA3);
    assign wr_fire = psel_in && penable_in && pready_reg && pwrite_in && pstrb_in[0];
    assign wr_cfg = wr_fire && (paddr_in == `CCA_ADDR_CONFIG);
    assign wr_d0 = wr_fire && (paddr_in == `CCA_ADDR_DATA0);
    assign wr_d1 = wr_fire && (paddr_in == `CCA_ADDR_DATA1);
    assign wr_d2 = wr_fire && (paddr_in == `CCA_ADDR_DATA2);
    assign wr_d3 = wr_fire && (paddr_in == `CCA_ADDR_DATA3);

    // The engine only runs in one of the five computing modes.
    always_comb begin
        unique case (cfg_reg.engine_mode_sel)
            cca_pkg::CCA_MODE_CS8,
            cca_pkg::CCA_MODE_CS32,
            cca_pkg::CCA_MODE_CRC16A,
            cca_pkg::CCA_MODE_CRC16B,
            cca_pkg::CCA_MODE_CRC32: engine_on = 1'b1;
            default:                 engine_on = 1'b0;
        endcase
    end

    // A low byte write ends the entry; it computes unless seeding or the engine is off.
    assign clear_cmd = wr_cfg && (pwdata_in[2:0] == 3'h7);
    assign start = wr_d0 && !cfg_reg.seed && engine_on;

    // Entry word: held upper bytes with the new low byte.
    assign entry = {upper_reg, pwdata_in[7:0]};

    // Width mask for the selected input size.
    always_comb begin
        unique case (cfg_reg.input_width_sel)
            2'h0:    mask_w = `CCA_MASK_8;
            2'h1:    mask_w = `CCA_MASK_16;
            2'h2:    mask_w = 32'h00ff_ffff;
            2'h3:    mask_w = `CCA_MASK_32;
        endcase
    end

    // Mirror the entry across each possible width, one bit per slice.
    for (genvar gi = 0; gi < 32; gi++) begin : g_rev
        assign rev32[gi] = entry[31 - gi];
        if (gi < 24) begin : g_24
            assign rev24[gi] = entry[23 - gi];
        end else begin : g_24z
            assign rev24[gi] = 1'b0;
        end
        if (gi < 16) begin : g_16
            assign rev16[gi] = entry[15 - gi];
        end else begin : g_16z
            assign rev16[gi] = 1'b0;
        end
        if (gi < 8) begin : g_8
            assign rev8[gi] = entry[7 - gi];
        end else begin : g_8z
            assign rev8[gi] = 1'b0;
        end
    end

    // Engine input word after optional mirroring.
    always_comb begin
        if (!cfg_reg.reverse) begin
            eng_word = entry & mask_w;
        end else begin
            unique case (cfg_reg.input_width_sel)
                2'h0:    eng_word = rev8;
                2'h1:    eng_word = rev16;
                2'h2:    eng_word = rev24;
                2'h3:    eng_word = rev32;
            endcase
        end
    end

    // Default seed and result width per mode.
    always_comb begin
        unique case (cfg_reg.engine_mode_sel)
            cca_pkg::CCA_MODE_CRC16A,
            cca_pkg::CCA_MODE_CRC16B: begin
                seed_dflt = `CCA_SEED_CRC16;
                res_mask = `CCA_MASK_16;
            end
            cca_pkg::CCA_MODE_CRC32: begin
                seed_dflt = `CCA_SEED_CRC32;
                res_mask = `CCA_MASK_32;
            end
            cca_pkg::CCA_MODE_CS8: begin
                seed_dflt = `CCA_SEED_CKSUM;
                res_mask = `CCA_MASK_8;
            end
            default: begin
                seed_dflt = `CCA_SEED_CKSUM;
                res_mask = `CCA_MASK_32;
            end
        endcase
    end

    // Datapath of one calculation step; the byte index walks up from bit 0.
    assign cur_byte = word_reg[{idx_reg, 3'b000} +: 8];
    assign carry_in = cfg_reg.carry_discard ? 1'b0 : carry_reg;

    // Byte and whole-word sums; the top bit of each is the carry out.
    assign sum9 = {1'b0, result_reg[7:0]} + {1'b0, cur_byte} + {8'h00, carry_in};
    assign sum33 = {1'b0, result_reg} + {1'b0, word_reg} + {32'h0, carry_in};

    // Next CRC state for the selected polynomial, one byte per step.
    always_comb begin
        unique case (cfg_reg.engine_mode_sel)
            cca_pkg::CCA_MODE_CRC16A:
                crc_next = crc_byte(result_reg, cur_byte, 1'b0, `CCA_POLY_CRC16A);
            cca_pkg::CCA_MODE_CRC16B:
                crc_next = crc_byte(result_reg, cur_byte, 1'b0, `CCA_POLY_CRC16B);
            default:
                crc_next = crc_byte(result_reg, cur_byte, 1'b1, `CCA_POLY_CRC32);
        endcase
    end

    // Configuration register; a clear command keeps the old mode.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_reg <= cca_pkg::cca_cfg_t'(`CCA_CONFIG_RST);
        end else if (wr_cfg) begin
            cfg_reg.input_width_sel <= pwdata_in[`CCA_CFG_WIDTH_HI:`CCA_CFG_WIDTH_LO];
            cfg_reg.reverse <= pwdata_in[`CCA_CFG_REVERSE];
            cfg_reg.carry_discard <= pwdata_in[`CCA_CFG_DISCARD];
            cfg_reg.seed <= pwdata_in[`CCA_CFG_SEED];
            if (!clear_cmd) begin
                cfg_reg.engine_mode_sel <= cca_pkg::cca_mode_t'(pwdata_in[2:0]);
            end
        end
    end

    // Upper data bytes held until the low byte completes the entry.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            upper_reg <= 24'h000000;
        end else begin
            if (wr_d1) begin
                upper_reg[7:0] <= pwdata_in[7:0];
            end
            if (wr_d2) begin
                upper_reg[15:8] <= pwdata_in[7:0];
            end
            if (wr_d3) begin
                upper_reg[23:16] <= pwdata_in[7:0];
            end
        end
    end

    // Sequencer: one byte per cycle, width + 1 cycles in all.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_reg <= cca_pkg::CCA_ST_IDLE;
            idx_reg <= 2'h0;
            last_reg <= 2'h0;
            word_reg <= `CCA_DATA_RST;
        end else if (clear_cmd || (wr_d0 && !start)) begin
            state_reg <= cca_pkg::CCA_ST_IDLE;
        end else if (start) begin
            state_reg <= cca_pkg::CCA_ST_CALC;
            idx_reg <= 2'h0;
            last_reg <= cfg_reg.input_width_sel;
            word_reg <= eng_word;
        end else begin
            unique case (state_reg)
                cca_pkg::CCA_ST_IDLE: begin
                    state_reg <= cca_pkg::CCA_ST_IDLE;
                end
                cca_pkg::CCA_ST_CALC: begin
                    if (idx_reg == last_reg) begin
                        state_reg <= cca_pkg::CCA_ST_IDLE;
                    end else begin
                        idx_reg <= idx_reg + 2'h1;
                    end
                end
                default: begin
                    state_reg <= cca_pkg::CCA_ST_IDLE;  // An illegal code falls back to idle.
                end
            endcase
        end
    end

    // Running result and checksum carry.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            result_reg <= `CCA_DATA_RST;
            carry_reg <= 1'b0;
        end else if (clear_cmd) begin
            result_reg <= seed_dflt;
            carry_reg <= 1'b0;
        end else if (wr_d0 && cfg_reg.seed) begin
            result_reg <= entry & res_mask;
            carry_reg <= 1'b0;
        end else if (state_reg == cca_pkg::CCA_ST_CALC && !start) begin
            unique case (cfg_reg.engine_mode_sel)
                cca_pkg::CCA_MODE_CS8: begin
                    result_reg <= {24'h000000, sum9[7:0]};
                    carry_reg <= sum9[8];
                end
                cca_pkg::CCA_MODE_CS32: begin
                    if (idx_reg == last_reg) begin
                        result_reg <= sum33[31:0];
                        carry_reg <= sum33[32];
                    end
                end
                cca_pkg::CCA_MODE_CRC16A,
                cca_pkg::CCA_MODE_CRC16B,
                cca_pkg::CCA_MODE_CRC32: begin
                    result_reg <= crc_next;
                end
                default: begin
                    result_reg <= result_reg;
                end
            endcase
        end
    end

    // Read byte selection; data reads return the result unmirrored.
    always_comb begin
        rd_byte = 8'h00;
        if (paddr_in == `CCA_ADDR_CONFIG) begin
            rd_byte = {cfg_reg.input_width_sel, cfg_reg.reverse,
                       cfg_reg.carry_discard, cfg_reg.seed, 2'b00,
                       state_reg == cca_pkg::CCA_ST_CALC};
        end else if (paddr_in == `CCA_ADDR_DATA0) begin
            rd_byte = result_reg[7:0];
        end else if (paddr_in == `CCA_ADDR_DATA1) begin
            rd_byte = result_reg[15:8];
        end else if (paddr_in == `CCA_ADDR_DATA2) begin
            rd_byte = result_reg[23:16];
        end else if (paddr_in == `CCA_ADDR_DATA3) begin
            rd_byte = result_reg[31:24];
        end
    end

    // APB answer: registered ready, data and error, no wait states.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_hit;
            prdata_reg <= pwrite_in ? 32'h0000_0000 : {24'h000000, rd_byte};
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
    end

    // Busy output flop mirrors the sequencer state.
    // It drops with the last byte step, so it stands for the width plus one cycles.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= start || (state_reg == cca_pkg::CCA_ST_CALC && idx_reg != last_reg
                                  && !clear_cmd && !wr_d0);
        end
    end

    // Bus answer ports come straight from their flops.
    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;

endmodule

/* File: cca_accel_properties.sv */
`include "cca_regs.svh"

module cca_accel_properties (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg_reg;
    logic [2:0] mode_reg;
    logic       acc, wr0, wrc, calc, mapped;

    // Decode completed writes and whether a data entry starts the engine.
    assign acc    = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
    assign wr0    = acc && paddr_in == `CCA_ADDR_DATA0;
    assign wrc    = acc && paddr_in == `CCA_ADDR_CONFIG;
    assign calc   = wr0 && !cfg_reg[3] && mode_reg inside {[3'h1:3'h5]};
    assign mapped = paddr_in inside {`CCA_ADDR_CONFIG, `CCA_ADDR_DATA0, `CCA_ADDR_DATA1, `CCA_ADDR_DATA2,
                                     `CCA_ADDR_DATA3};

    // Shadow of the configuration; the clear code keeps the earlier mode.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_reg  <= 8'h00;
            mode_reg <= 3'h0;
        end else if (wrc) begin
            cfg_reg <= pwdata_in[7:0];
            if (pwdata_in[2:0] != 3'h7) begin
                mode_reg <= pwdata_in[2:0];
            end
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // Bus answer timing and read data shape.
    a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside access");
    a_rdata_byte_only: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
        else $error("read data above byte");
    a_unmapped_err: assert property (psel_in && !penable_in |=> pslverr_out == !$past(mapped))
        else $error("error flag wrong for address");
    // Calculation length follows the input width.
    a_busy_byte: assert property (calc && cfg_reg[7:6] == 2'b00 |=> busy_out ##1 !busy_out)
        else $error("8-bit busy length wrong");
    a_busy_half: assert property (calc && cfg_reg[7:6] == 2'b01 |=> busy_out[*2] ##1 !busy_out)
        else $error("16-bit busy length wrong");
    a_busy_triple: assert property (calc && cfg_reg[7:6] == 2'b10 |=> busy_out[*3] ##1 !busy_out)
        else $error("24-bit busy length wrong");
    a_busy_word: assert property (calc && cfg_reg[7:6] == 2'b11 |=> busy_out[*4] ##1 !busy_out)
        else $error("32-bit busy length wrong");
    a_busy_cause: assert property ($rose(busy_out) |-> $past(calc))
        else $error("busy without data entry");
    a_off_idle: assert property (wr0 && !cfg_reg[3] && mode_reg inside {3'h0, 3'h6} |=> !busy_out)
        else $error("disabled engine went busy");
    a_seed_idle: assert property (wr0 && cfg_reg[3] |=> !busy_out)
        else $error("seed entry started a calculation");
    a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !busy_out && !pready_out)
        else $error("outputs active in reset");
endmodule

/* File: cca_cpu_model.sv */
module cca_cpu_model (
    input  wire logic        clk_in,
    input  wire logic        pready_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [31:0] paddr_out,
    output logic      [31:0] pwdata_out,
    output logic      [3:0]  pstrb_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus is idle from time zero.
    initial begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 32'h0;
        pwdata_out  = 32'h0;
        pstrb_out   = 4'hf;
    end

    // One transfer: setup, then access held until ready is sampled high.
    // Only the bench watchdog ends a wait that never sees ready.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_out   <= 1'b1;
        pwrite_out <= w;
        paddr_out  <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (!pready_in);
        // A released bus shows the inverse of the last request, so stale values cannot pass.
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        pwrite_out  <= ~w;
        paddr_out   <= ~a;
        pwdata_out  <= ~d;
    endtask
endmodule

/* File: cca_accel_tb.sv */
`include "cca_regs.svh"

module cca_accel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, busy, cy;
    logic [31:0] paddr, pwdata, prdata, res, ent;
    logic [3:0]  pstrb;
    logic [7:0]  cfg;
    logic [2:0]  mode;
    logic [32:0] expq[$];
    int          miscompares, n_checks, seed;

    cca_accel cca_accel_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .busy_out(busy));
    cca_cpu_model cca_cpu_model_i (.clk_in(clk_sys_in), .pready_in(pready), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

    always #5 clk_sys_in = ~clk_sys_in;

    // Expected engine step for one entry, returning carry and result.
    function automatic logic [32:0] step(input logic [31:0] d);
        logic [31:0] x, s;
        logic        c, fb;
        int          nb;
        s  = res;
        c  = cy;
        x  = 32'h0;
        nb = 8 * (cfg[7:6] + 1);
        for (int i = 0; i < nb; i++) x[i] = cfg[5] ? d[nb-1-i] : d[i];
        if (mode == 3'h1) begin
            for (int i = 0; i < nb; i += 8) {c, s[7:0]} = s[7:0] + x[i+:8] + (c & !cfg[4]);
        end else if (mode == 3'h2) begin
            {c, s} = s + x + (c & !cfg[4]);
        end else if (mode inside {[3'h3:3'h5]}) begin
            for (int i = 0; i < nb; i++) begin
                fb = x[i] ^ (mode == 3'h5 ? s[31] : s[15]);
                s  = (s << 1) ^ (fb ? (mode == 3'h3 ? 32'h8005 : mode == 3'h4 ? 32'h1021 : 32'h04c11db7) : 32'h0);
            end
            if (mode != 3'h5) s[31:16] = 16'h0;
        end
        return {c, s};
    endfunction

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        cca_cpu_model_i.xfer(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [31:0] a, input logic [32:0] e);
        expq.push_back(e);
        cca_cpu_model_i.xfer(1'b0, a, 32'h0);
    endtask

    // Write the configuration and follow the clear command in the model.
    task automatic setcfg(input logic [7:0] v);
        wr(`CCA_ADDR_CONFIG, v);
        cfg = v;
        if (v[2:0] == 3'h7) begin
            res = mode inside {3'h3, 3'h4} ? 32'hffff : mode == 3'h5 ? 32'hffffffff : 32'h0;
            cy  = 1'b0;
        end else begin
            mode = v[2:0];
        end
    endtask

    // Enter a word, upper bytes first and the lowest byte last.
    task automatic entry(input logic [31:0] d);
        for (int k = cfg[7:6]; k >= 1; k--) begin
            wr(`CCA_ADDR_DATA0 + 4 * k, d[8*k+:8]);
            ent[8*k+:8] = d[8*k+:8];
        end
        wr(`CCA_ADDR_DATA0, d[7:0]);
        ent[7:0] = d[7:0];
        if (cfg[3]) res = ent & (mode == 3'h1 ? 32'hff : mode inside {3'h3, 3'h4} ? 32'hffff : 32'hffffffff);
        else if (mode inside {[3'h1:3'h5]}) {cy, res} = step(ent);
    endtask

    // Read the result bytes and the configuration once the engine has settled.
    task automatic chk();
        repeat (4) @(posedge clk_sys_in);
        for (int k = 0; k < 4; k++) rd(`CCA_ADDR_DATA0 + 4 * k, {25'h0, res[8*k+:8]});
        rd(`CCA_ADDR_CONFIG, {25'h0, cfg[7:3], 3'h0});
    endtask

    // Compare each read answer with the oldest expectation.
    always @(posedge clk_sys_in) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            n_checks++;
            if ({pslverr, prdata} !== expq[0]) begin
                miscompares++;
                $display("Error at %0t: got %h expected %h", $time, {pslverr, prdata}, expq[0]);
            end
            void'(expq.pop_front());
        end
    end

    task automatic summarize();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Cut a hung run short.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        summarize();
    end

    // Main sequence of tests.
    initial begin
        clk_sys_in = 1'b0;
        rst_in = 1'b1;
        seed = 32'h95d3;
        {cfg, mode, res, ent, cy} = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        chk();
        rd(32'h0000_0100, {1'b1, 32'h0});
        $display("test 1 done");
        for (int m = 1; m <= 5; m++) begin
            for (int w = 0; w < 4; w++) begin
                setcfg({w[1:0], 1'($random(seed)), 1'($random(seed)), 1'b0, m[2:0]});
                setcfg(cfg | 8'h07);
                entry($random(seed));
                if (w == 3) rd(`CCA_ADDR_CONFIG, {25'h0, cfg[7:3], 3'h1});
                entry($random(seed));
                chk();
            end
        end
        $display("test 2 done");
        setcfg(8'hed);
        entry($random(seed));
        chk();
        setcfg(8'he5);
        entry($random(seed));
        chk();
        setcfg(8'h09);
        entry($random(seed));
        chk();
        $display("test 3 done");
        setcfg(8'hc6);
        entry($random(seed));
        chk();
        setcfg(8'hc0);
        entry($random(seed));
        chk();
        $display("test 4 done");
        summarize();
    end
endmodule

bind cca_accel cca_accel_properties cca_accel_properties_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .busy_out(busy_out));
